// >>> logic/seal_pkg.sv
`default_nettype none
package seal_pkg;

  // Array geometry: 16-bit byte address, 4-byte words, 128-byte rows
  localparam int ADDR_W      = 16;
  localparam int PAGE_BYTES  = 128;
  localparam int PAGE_W      = 7;
  localparam int WORD_BYTES  = 4;
  localparam int DATA_W      = 32;
  localparam int CHK_W       = 6;
  localparam int WORD_AW     = ADDR_W - 2;
  localparam int WORDS       = 1 << WORD_AW;
  localparam int PAGE_WORDS  = PAGE_BYTES / WORD_BYTES;

  // Select byte layout
  localparam logic [3:0] TYPE_ID   = 4'h5;  // Arbitrary value, stands in for the real type code
  localparam int         SEL_ID_LO = 4;
  localparam int         SEL_CE_LO = 1;
  localparam int         SEL_RW    = 0;

  // Bit counting within a byte slot
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_STOP  = 4'h1;

  // Delivered contents: every byte all ones
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;

  // Internal write time, plain default, and its cycle count (rounded up)
  localparam int CLK_PERIOD_NS          = 10;
  localparam int INTERNAL_WRITE_TIME_NS = 5000;
  localparam int WRITE_CYCLES = (INTERNAL_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W      = 16;

  // Bus-facing states and the role of the byte being received
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK, ST_BUSY} seal_state_t;
  typedef enum logic [1:0] {PH_DEV, PH_HI, PH_LO, PH_DATA} seal_phase_t;

  // Column code of data bit j: the j-th six-bit value that is not a power of two
  function automatic logic [CHK_W-1:0] seal_ecc_col(input int unsigned j);
    logic [CHK_W-1:0] r;
    int unsigned      k;
    r = '0;
    k = 0;
    for (int unsigned n = 3; n < 64; n++) begin
      if ((n & (n - 1)) != 0) begin
        if (k == j) r = n[CHK_W-1:0];
        k++;
      end
    end
    return r;
  endfunction : seal_ecc_col

  // Six check bits over one word
  function automatic logic [CHK_W-1:0] seal_ecc_check(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int unsigned j = 0; j < DATA_W; j++) begin
      if (d[j]) c = c ^ seal_ecc_col(j);
    end
    return c;
  endfunction : seal_ecc_check

  // Correct a single flipped data bit; a flipped check bit leaves data alone
  function automatic logic [DATA_W-1:0] seal_ecc_fix(input logic [CHK_W+DATA_W-1:0] w);
    logic [CHK_W-1:0]  syn;
    logic [DATA_W-1:0] d;
    d   = w[DATA_W-1:0];
    syn = w[CHK_W+DATA_W-1:DATA_W] ^ seal_ecc_check(d);
    for (int unsigned j = 0; j < DATA_W; j++) begin
      if (syn == seal_ecc_col(j)) d[j] = ~d[j];
    end
    return d;
  endfunction : seal_ecc_fix

endpackage : seal_pkg
`default_nettype wire

// >>> logic/seal_top.sv
// What this block does
// - Ack write select, then both address bytes
// - Inhibit high before data: no write, no ack
// - Address is high byte then low byte
// - Only Stop in tenth slot starts write
// - Counter ends past last modified byte
// - Busy: data line released, bus ignored
// - Byte write acked unless inhibited
// - Page write holds up to 128 bytes
// - Page bytes acked, or nacked when inhibited
// - Page bytes step only low seven bits
// - Six check bits correct one bit per word
// - Every write rewrites whole word with checks
// - Select not acked while busy, acked after
// - Reads ignore the inhibit input
// - Each read byte steps counter by one
// - Random read: dummy write, restart, read
// - Current read serves byte at counter
// - Master ack keeps sequential bytes coming
// - Counter wraps from top address to zero
// - No master ack ends read, go standby
// - Answer only matching type and chip select
// - Watch for Start, silent until one
`timescale 1ns/1ps
`default_nettype none
module seal_top
  import seal_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Two-wire bus, data line open drain
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Straps and write protect
  input  wire logic chip_sel_bit0,
  input  wire logic chip_sel_bit1,
  input  wire logic chip_sel_bit2,
  input  wire logic write_inhibit_n,
  // Status
  output logic      write_busy
);

  // Synchroniser stages; stage one feeds only stage two
  logic [5:0]          pin_s1_reg;    // Raw pins, first stage
  logic [5:0]          pin_s2_reg;    // Safe levels, inhibit on top
  logic                scl_d_reg;     // Previous clock level for edges
  logic                sda_d_reg;     // Previous data level for edges

  // Bus engine state
  seal_state_t         state_reg;     // Protocol state
  seal_phase_t         phase_reg;     // Role of current received byte
  logic [3:0]          bit_cnt_reg;   // Bits clocked in this slot
  logic [7:0]          rx_shift_reg;  // Incoming byte
  logic [7:0]          tx_shift_reg;  // Outgoing byte
  logic                rw_reg;        // Direction of last select
  logic                master_ack_reg;// Sampled master acknowledge
  logic                ack_drive_reg; // We acknowledge this slot
  logic [ADDR_W-1:0]   addr_reg;      // Internal address counter
  logic [7:0]          addr_hi_reg;   // Held upper address byte
  logic                inhibit_reg;   // Inhibit seen since Start
  logic                wr_pending_reg;// Data bytes buffered
  logic                sda_oe_reg;    // Pull data line low

  // Page buffer and write engine
  logic [7:0]          page_buf [0:PAGE_BYTES-1];  // Buffered data bytes
  logic [PAGE_BYTES-1:0] buf_valid_reg;             // Bytes present in buffer
  logic [5:0]          word_idx_reg;  // Word being committed
  logic [TIMER_W-1:0]  timer_reg;     // Internal write time count
  logic [CHK_W+DATA_W-1:0] mem [0:WORDS-1];         // Array with check bits

  // Decoded bus events
  logic                scl_s;
  logic                sda_s;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic                byte_done;
  logic                data_take;
  logic [7:0]          rd_byte;
  logic                sel_match;
  logic                wr_done;
  logic [WORD_AW-1:0]  wr_word_addr;
  logic [DATA_W-1:0]   wr_word_data;
  logic                wr_word_en;

  assign scl_s     = pin_s2_reg[0];
  assign sda_s     = pin_s2_reg[1];
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  // Data edges while the clock stays high are Start and Stop
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign byte_done = scl_fall && state_reg == ST_RX && bit_cnt_reg == BITS_BYTE;
  // Inhibited data bytes are dropped, so memory is never touched
  assign data_take = byte_done && phase_reg == PH_DATA && !inhibit_reg;
  assign sel_match = rx_shift_reg[7:SEL_ID_LO] == TYPE_ID &&
                     rx_shift_reg[SEL_ID_LO-1:SEL_CE_LO] == {pin_s2_reg[4], pin_s2_reg[3], pin_s2_reg[2]};

  // Read path corrects the word before picking the byte
  always_comb begin
    logic [DATA_W-1:0] w;
    w       = '0;
    w       = seal_ecc_fix(mem[addr_reg[ADDR_W-1:2]]);
    rd_byte = w[addr_reg[1:0]*8 +: 8];
  end

  // Open drain: only ever pull low
  assign sda_out    = 1'b0;
  assign sda_oe     = sda_oe_reg;
  assign write_busy = state_reg == ST_BUSY;

  // Pin synchronisers and edge history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1_reg <= 6'h1f;
      pin_s2_reg <= 6'h1f;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
    end else begin
      pin_s1_reg <= {write_inhibit_n, chip_sel_bit2, chip_sel_bit1, chip_sel_bit0, sda_in, scl_in};
      pin_s2_reg <= pin_s1_reg;
      scl_d_reg  <= pin_s2_reg[0];
      sda_d_reg  <= pin_s2_reg[1];
    end
  end

  // Protocol engine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg      <= ST_IDLE;
      phase_reg      <= PH_DEV;
      bit_cnt_reg    <= '0;
      rx_shift_reg   <= '0;
      tx_shift_reg   <= '0;
      rw_reg         <= 1'b0;
      master_ack_reg <= 1'b0;
      ack_drive_reg  <= 1'b0;
      addr_reg       <= '0;
      addr_hi_reg    <= '0;
      inhibit_reg    <= 1'b0;
      wr_pending_reg <= 1'b0;
      sda_oe_reg     <= 1'b0;
    end else if (state_reg == ST_BUSY) begin
      // Deaf and released until the commit and timer finish
      sda_oe_reg <= 1'b0;
      if (wr_done) begin
        state_reg <= ST_IDLE;
      end
    end else if (start_det) begin
      // Start or repeated Start always begins a fresh select byte
      state_reg      <= ST_RX;
      phase_reg      <= PH_DEV;
      bit_cnt_reg    <= '0;
      sda_oe_reg     <= 1'b0;
      wr_pending_reg <= 1'b0;
      inhibit_reg    <= pin_s2_reg[5];
    end else if (stop_det) begin
      sda_oe_reg <= 1'b0;
      // Commit only when Stop follows an ack slot of a data byte
      if (state_reg == ST_RX && phase_reg == PH_DATA && bit_cnt_reg == BIT_STOP && wr_pending_reg) begin
        state_reg <= ST_BUSY;
      end else begin
        state_reg <= ST_IDLE;
      end
    end else begin
      // Inhibit is sticky from Start through the address bytes
      if (phase_reg != PH_DATA && (state_reg == ST_RX || state_reg == ST_ACK)) begin
        inhibit_reg <= inhibit_reg | pin_s2_reg[5];
      end
      if (scl_rise) begin
        unique case (state_reg)
          ST_RX: begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end
          ST_TX: begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          ST_RACK: begin
            master_ack_reg <= ~sda_s;
          end
          ST_IDLE, ST_ACK, ST_BUSY: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state_reg)
          ST_RX: begin
            if (bit_cnt_reg == BITS_BYTE) begin
              unique case (phase_reg)
                PH_DEV: begin
                  // Mismatch deselects without a word on the line
                  if (sel_match) begin
                    rw_reg        <= rx_shift_reg[SEL_RW];
                    ack_drive_reg <= 1'b1;
                    sda_oe_reg    <= 1'b1;
                    state_reg     <= ST_ACK;
                  end else begin
                    state_reg <= ST_IDLE;
                  end
                end
                PH_HI: begin
                  addr_hi_reg   <= rx_shift_reg;
                  ack_drive_reg <= 1'b1;
                  sda_oe_reg    <= 1'b1;
                  state_reg     <= ST_ACK;
                end
                PH_LO: begin
                  addr_reg      <= {addr_hi_reg, rx_shift_reg};
                  ack_drive_reg <= 1'b1;
                  sda_oe_reg    <= 1'b1;
                  state_reg     <= ST_ACK;
                end
                PH_DATA: begin
                  // Only the low row bits step, so overflow wraps in the row
                  if (!inhibit_reg) begin
                    addr_reg[PAGE_W-1:0] <= addr_reg[PAGE_W-1:0] + 7'h01;
                    wr_pending_reg       <= 1'b1;
                  end
                  ack_drive_reg <= ~inhibit_reg;
                  sda_oe_reg    <= ~inhibit_reg;
                  state_reg     <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            // End of ninth clock: release, then receive or start sending
            bit_cnt_reg <= '0;
            if (phase_reg == PH_DEV && rw_reg) begin
              tx_shift_reg <= rd_byte;
              sda_oe_reg   <= ~rd_byte[7];
              addr_reg     <= addr_reg + 16'h0001;
              state_reg    <= ST_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_RX;
              unique case (phase_reg)
                PH_DEV:  phase_reg <= PH_HI;
                PH_HI:   phase_reg <= PH_LO;
                PH_LO:   phase_reg <= PH_DATA;
                PH_DATA: phase_reg <= PH_DATA;
              endcase
            end
          end
          ST_TX: begin
            if (bit_cnt_reg == BITS_BYTE) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_RACK;
            end else begin
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              sda_oe_reg   <= ~tx_shift_reg[6];
            end
          end
          ST_RACK: begin
            bit_cnt_reg <= '0;
            if (master_ack_reg) begin
              tx_shift_reg <= rd_byte;
              sda_oe_reg   <= ~rd_byte[7];
              addr_reg     <= addr_reg + 16'h0001;
              state_reg    <= ST_TX;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          ST_IDLE, ST_BUSY: begin
          end
        endcase
      end
    end
  end

  // Page buffer data, no reset needed since the valid mask gates it
  always_ff @(posedge clk) begin
    if (data_take) begin
      page_buf[addr_reg[PAGE_W-1:0]] <= rx_shift_reg;
    end
  end

  // Valid mask, emptied at every Start outside a write cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_valid_reg <= '0;
    end else if (state_reg != ST_BUSY && start_det) begin
      buf_valid_reg <= '0;
    end else if (data_take) begin
      buf_valid_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // Merge buffered bytes into the corrected old word
  always_comb begin
    logic [DATA_W-1:0] w;
    logic [PAGE_W-1:0] b;
    w            = '0;
    b            = '0;
    wr_word_addr = {addr_reg[ADDR_W-1:PAGE_W], word_idx_reg[4:0]};
    w            = seal_ecc_fix(mem[wr_word_addr]);
    wr_word_en   = 1'b0;
    for (int i = 0; i < WORD_BYTES; i++) begin
      b = {word_idx_reg[4:0], 2'(i)};
      if (buf_valid_reg[b]) begin
        w[i*8 +: 8] = page_buf[b];
        wr_word_en  = 1'b1;
      end
    end
    wr_word_en   = wr_word_en && state_reg == ST_BUSY && word_idx_reg < 6'(PAGE_WORDS);
    wr_word_data = w;
  end

  // Write engine: one word per cycle, then wait out the write time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_idx_reg <= '0;
      timer_reg    <= '0;
    end else if (state_reg != ST_BUSY) begin
      word_idx_reg <= '0;
      timer_reg    <= '0;
    end else if (word_idx_reg < 6'(PAGE_WORDS)) begin
      word_idx_reg <= word_idx_reg + 6'h01;
    end else begin
      timer_reg <= timer_reg + 16'h0001;
    end
  end

  assign wr_done = state_reg == ST_BUSY && word_idx_reg == 6'(PAGE_WORDS) &&
                   timer_reg == TIMER_W'(WRITE_CYCLES - 1);

  // Array storage; a touched word is rewritten whole with fresh checks
  // Plain always, since the delivered contents are preloaded by a second process
  always @(posedge clk) begin
    if (wr_word_en) begin
      mem[wr_word_addr] <= {seal_ecc_check(wr_word_data), wr_word_data};
    end
  end

  // Delivered contents: all ones with matching checks
  initial begin
    for (int i = 0; i < WORDS; i++) begin
      mem[i] = {seal_ecc_check(ERASED_WORD), ERASED_WORD};
    end
  end

endmodule : seal_top
`default_nettype wire

// >>> tb/seal_master.sv
`timescale 1ns/1ps
`default_nettype none
module seal_master (
  // Clock
  input  wire logic clk,
  // Device side of the data line
  input  wire logic sda_oe,
  input  wire logic sda_out,
  // Resolved bus lines
  output logic      scl,
  output logic      sda
);
  logic       sda_m;  // Master's own pull, high when released
  logic [7:0] res;    // Last ack level or read byte
  event       got;    // Fires once res is valid
  // Wired-and with pull-up, so a released line reads high
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
  // Clock stands high between frames
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
    res   = 8'h00;
  end
  // Wait a number of falling clock edges
  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask : hc
  // One bit slot of 16 clocks; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    hc(4);
    sda_m = b;
    hc(4);
    scl = 1'b1;
    hc(4);
    r = sda;
    hc(4);
  endtask : bit_io
  // Start, also usable as a repeated Start mid-frame
  task automatic start;
    scl = 1'b0;
    hc(4);
    sda_m = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(4);
    sda_m = 1'b0;
    hc(4);
  endtask : start
  // Stop right after the ack slot
  task automatic stop;
    scl = 1'b0;
    hc(4);
    sda_m = 1'b0;
    hc(4);
    scl = 1'b1;
    hc(4);
    sda_m = 1'b1;
    hc(4);
  endtask : stop
  // Send a byte MSB first, then release for the ack
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    res = {7'h00, r};
    ->got;
  endtask : wbyte
  // Read a byte, then ack (0) or end the run (1)
  task automatic rbyte(input logic nack);
    logic       r;
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(nack, r);
    res = v;
    ->got;
  endtask : rbyte
endmodule : seal_master
`default_nettype wire

// >>> tb/seal_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module seal_monitor
  import seal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  // Protect and status
  input wire logic write_inhibit_n,
  input wire logic write_busy
);
  logic       sda_d_reg;     // Data level one clock ago
  logic       frame_reg;     // Between a Start and a Stop
  logic [3:0] stop_win_reg;  // Short window after a raw Stop
  logic [9:0] busy_cnt_reg;  // Length of the running busy stretch
  wire  logic start_w = scl_in & sda_d_reg & ~sda_in;
  wire  logic stop_w  = scl_in & ~sda_d_reg & sda_in;
  // Raw edge finder; the design sees the same edges a few clocks later
  always_ff @(posedge clk or posedge reset) begin
    if (reset) sda_d_reg <= 1'b1;
    else sda_d_reg <= sda_in;
  end
  // Frame tracking and Stop window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_reg    <= 1'b0;
      stop_win_reg <= 4'h0;
    end else begin
      if (start_w) frame_reg <= 1'b1;
      else if (stop_w) frame_reg <= 1'b0;
      // Window covers the sync pipeline with margin
      stop_win_reg <= stop_w ? 4'hf : (stop_win_reg != 4'h0 ? stop_win_reg - 4'h1 : 4'h0);
    end
  end
  // Busy length counter, held for one cycle after busy drops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) busy_cnt_reg <= 10'h000;
    else busy_cnt_reg <= write_busy ? busy_cnt_reg + 10'h001 : 10'h000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_busy_quiet: assert property (write_busy |-> !sda_oe)
    else $error("data line driven during write cycle");
  a_busy_length: assert property (!write_busy && busy_cnt_reg != 10'h000 |->
    busy_cnt_reg >= WRITE_CYCLES && busy_cnt_reg <= WRITE_CYCLES + 64) else $error("write cycle length off");
  a_busy_after_stop: assert property ($rose(write_busy) |-> stop_win_reg != 4'h0)
    else $error("write cycle started without a Stop");
  a_busy_lines_high: assert property ($rose(write_busy) |-> scl_in && sda_in)
    else $error("write cycle started with bus not idle");
  a_busy_not_inhibited: assert property ($rose(write_busy) |-> !write_inhibit_n)
    else $error("write cycle started while inhibited");
  a_silent_outside: assert property (!frame_reg |-> !sda_oe)
    else $error("data line driven outside a frame");
  a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while clock high");
  a_oe_holds_slot: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("data line pull too short");
endmodule : seal_monitor
bind seal_top seal_monitor u_mon (.clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe(sda_oe), .write_inhibit_n(write_inhibit_n), .write_busy(write_busy));
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import seal_pkg::*;
  logic        clk, reset, scl, sda, sda_out, sda_oe, write_busy, write_inhibit_n;
  logic [2:0]  ce;           // Chip-enable straps
  logic [7:0]  q[$];         // Expected results, oldest first
  logic [7:0]  d[4];         // Data bytes of the current test
  logic [15:0] a;            // Random word address
  int          mismatches;
  int          n_checks;
  seal_top DUT (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_sel_bit0(ce[0]), .chip_sel_bit1(ce[1]), .chip_sel_bit2(ce[2]),
    .write_inhibit_n(write_inhibit_n), .write_busy(write_busy));
  seal_master m (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  function automatic logic [7:0] sel(input logic rw);
    return {TYPE_ID, ce, rw};
  endfunction : sel
  // Bus helpers; each notes its expected result first
  task automatic wb(input logic [7:0] b, input logic e);
    q.push_back({7'h00, e});
    m.wbyte(b);
  endtask : wb
  task automatic rb(input logic [7:0] e, input logic nack);
    q.push_back(e);
    m.rbyte(nack);
  endtask : rb
  task automatic hdr(input logic [15:0] ad);
    m.start();
    wb(sel(1'b0), 1'b0);
    wb(ad[15:8], 1'b0);
    wb(ad[7:0], 1'b0);
  endtask : hdr
  task automatic wr(input logic [15:0] ad, input int n);
    hdr(ad);
    for (int i = 0; i < n; i++) wb(d[i], 1'b0);
    m.stop();
  endtask : wr
  task automatic rd_at(input logic [15:0] ad);
    hdr(ad);
    m.start();
    wb(sel(1'b1), 1'b0);
  endtask : rd_at
  // Busy lags the Stop by the input sync pipeline
  task automatic busy_is(input logic e);
    m.hc(2);
    check("busy", {7'h00, write_busy}, {7'h00, e});
  endtask : busy_is
  task automatic wait_idle;
    for (int k = 0; k < 1000 && write_busy !== 1'b0; k++) @(negedge clk);
    check("busy_end", {7'h00, write_busy}, 8'h00);
  endtask : wait_idle
  // Watcher: each result on the bus is matched to the oldest note
  initial begin
    forever begin
      @(m.got);
      check("bus", m.res, q.pop_front());
    end
  end
  // Watchdog well above the expected run of some 10k cycles
  initial begin
    #400us;
    mismatches++;
    stop_test();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h20e0dd91));
    mismatches      = 0;
    n_checks        = 0;
    reset           = 1'b1;
    write_inhibit_n = 1'b0;
    ce              = 3'($urandom);
    repeat (4) @(negedge clk);
    reset = 1'b0;
    check("oe_reset", {7'h00, sda_oe}, 8'h00);
    check("busy_reset", {7'h00, write_busy}, 8'h00);
    m.hc(4);
    // Wrong straps, then wrong type code, both refused
    for (int i = 0; i < 2; i++) begin
      m.start();
      wb(i == 0 ? {TYPE_ID, ~ce, 1'b0} : {~TYPE_ID, ce, 1'b0}, 1'b1);
      m.stop();
    end
    // Aligned word write away from row zero and the top row
    a = {2'b01, 12'($urandom), 2'b00};
    for (int i = 0; i < 4; i++) d[i] = 8'($urandom);
    wr(a, 4);
    busy_is(1'b1);
    // Poll while busy is refused, then a read lands past the word
    m.start();
    wb(sel(1'b0), 1'b1);
    m.stop();
    wait_idle();
    m.start();
    wb(sel(1'b1), 1'b0);
    rb(8'hff, 1'b1);
    m.stop();
    // Flip one stored data bit of the first byte; reads must still return it
    DUT.mem[a[15:2]][0] = ~DUT.mem[a[15:2]][0];
    // Random read running on sequentially
    rd_at(a);
    for (int i = 0; i < 4; i++) rb(d[i], i == 3);
    m.stop();
    // Inhibited write: data refused, memory kept, reads unaffected
    write_inhibit_n = 1'b1;
    hdr(a);
    wb(~d[0], 1'b1);
    wb(~d[1], 1'b1);
    m.stop();
    busy_is(1'b0);
    rd_at(a);
    rb(d[0], 1'b0);
    rb(d[1], 1'b1);
    m.stop();
    write_inhibit_n = 1'b0;
    // Address-only header then Stop starts no write
    hdr(a);
    m.stop();
    busy_is(1'b0);
    // Row roll-over in row zero
    for (int i = 0; i < 3; i++) d[i] = 8'($urandom);
    wr(16'h007f, 3);
    busy_is(1'b1);
    wait_idle();
    // Reads cross rows and wrap from the top address
    rd_at(16'h007f);
    rb(d[0], 1'b0);
    rb(8'hff, 1'b1);
    m.stop();
    rd_at(16'hffff);
    rb(8'hff, 1'b0);
    rb(d[1], 1'b0);
    rb(d[2], 1'b1);
    m.stop();
    stop_test();
  end
endmodule : tb
`default_nettype wire
